// ### design/clock_ctrl_pkg.sv
package clock_ctrl_pkg;
   // Register byte addresses
   localparam logic [31:0] MISC_OFS = 32'h4002_8000;
   localparam logic [31:0] DIV_OFS = 32'h4002_8004;
   localparam logic [31:0] GATE_OFS = 32'h4002_8014;
   localparam logic [31:0] STAT_OFS = 32'h4002_8018;
   // Reset values
   localparam logic [15:0] MISC_RST = 16'h0041;
   localparam logic [15:0] DIV_RST = 16'h0200;
   localparam logic [15:0] GATE_RST = 16'h0040;
   localparam logic [15:0] STAT_RST = 16'h0000;
   // Writable bits; read-only reserved bits stay zero
   localparam logic [15:0] MISC_WMASK = 16'hEFF3;
   localparam logic [15:0] DIV_WMASK = 16'h0707;
   localparam logic [15:0] STAT_W1C = 16'h6006;
   // Field positions
   localparam int ROOT_SEL_LSB = 0;
   localparam int PLL_REF_BIT = 11;
   localparam int HDIV_LSB = 0;
   localparam int PDIV_LSB = 8;
   localparam int LOCK_BIT = 0;
   localparam int LOCK_GOT_BIT = 1;
   localparam int LOCK_LOST_BIT = 2;
   localparam int XTAL_OK_BIT = 12;
   localparam int XTAL_LOST_BIT = 13;
   localparam int XTAL_GOT_BIT = 14;
   // Root source codes; the reserved code is used inside for the slow oscillator
   localparam logic [1:0] SEL_FAST = 2'h0;
   localparam logic [1:0] SEL_PLL = 2'h1;
   localparam logic [1:0] SEL_RSVD = 2'h2;
   localparam logic [1:0] SEL_EXT = 2'h3;
   localparam logic [1:0] SRC_SLOW = 2'h2;
   // Analog clock is root divided by four
   localparam int ACLK_LOG2 = 2;
   localparam int CLK_PERIOD_NS = 10;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } reg_req_t;

   typedef struct packed {
      logic fast_internal_osc;
      logic system_pll;
      logic slow_internal_osc;
      logic crystal_osc;
      logic external_clock_input;
   } osc_in_t;

   typedef struct packed {
      logic root_system_clock;
      logic hclk;
      logic pclk;
      logic aclk;
      logic pll_ref;
   } clk_out_t;

   typedef enum logic [1:0] {
      MX_FOLLOW = 2'b00,
      MX_DRAIN = 2'b01,
      MX_WAIT_NEW = 2'b11
   } mux_state_t;
endpackage

// ### design/glitch_free_mux.sv
`timescale 1ns/1ps
module glitch_free_mux
   import clock_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Sources and select
   input wire logic [3:0] src,
   input wire logic [1:0] sel,
   // Output
   output logic out_q,
   output logic busy_q
);
   import clock_ctrl_pkg::*;

   typedef struct packed {
      mux_state_t st;
      logic [1:0] cur;
      logic [1:0] tgt;
      logic out;
   } mux_st_t;

   mux_st_t s_q;
   mux_st_t s_d;

   always_comb
   begin
      s_d = s_q;
      case (s_q.st)
         MX_FOLLOW:
         begin
            s_d.out = src[s_q.cur];
            if (sel != s_q.cur)
            begin
               s_d.st = MX_DRAIN;
            end
         end
         MX_DRAIN:
         begin
            // Let the old source finish its high phase, then park low
            s_d.out = src[s_q.cur];
            if (!src[s_q.cur])
            begin
               s_d.tgt = sel;
               s_d.st = MX_WAIT_NEW;
            end
         end
         MX_WAIT_NEW:
         begin
            // Join the new source only while it is low: no short pulse
            s_d.out = 1'b0;
            if (!src[s_q.tgt])
            begin
               s_d.cur = s_q.tgt;
               s_d.st = MX_FOLLOW;
            end
         end
         default:
         begin
            s_d.st = MX_FOLLOW;
            s_d.out = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_q <= '{st: MX_FOLLOW, cur: SEL_PLL, tgt: SEL_PLL, out: 1'b0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign out_q = s_q.out;
   assign busy_q = (s_q.st != MX_FOLLOW);

   property p_park_low;
      @(posedge clk) disable iff (!rstn)
      s_q.st == MX_WAIT_NEW |=> !out_q;
   endproperty
   a_park_low: assert property (p_park_low) else $error("output not parked low during switch");

   property p_switch_start;
      @(posedge clk) disable iff (!rstn)
      (s_q.st == MX_FOLLOW && sel != s_q.cur) |=> s_q.st == MX_DRAIN;
   endproperty
   a_switch_start: assert property (p_switch_start) else $error("select change not taken");

   property p_no_short_high;
      @(posedge clk) disable iff (!rstn)
      $rose(out_q) |-> $past(src[s_q.cur]) && s_q.st != MX_WAIT_NEW;
   endproperty
   a_no_short_high: assert property (p_no_short_high) else $error("output rose without source");
endmodule // glitch_free_mux

// ### design/clock_sel_div.sv
// Operation
// - Root clock selectable from fast internal oscillator or PLL; PLL by default.
// - External clock pin may be chosen as root clock for test.
// - Memory-bus clock and peripheral clock are derived from root clock.
// - Analog clock is root clock divided by four.
// - After reset the root clock comes from the PLL.
// - PLL reference is the fast internal oscillator after reset.
// - Divider field bits 2 to 0 divide by 1 up to 128.
// - Crystal stability is reported in status bits 14 to 12.
// - PLL lock is reported in status bits 2 to 0.
// - A 32 kHz slow oscillator serves as clock in low-power mode.
// - A 16 MHz crystal oscillator may serve as PLL reference.
// - Select code 00 fast osc, 01 PLL, 11 external pin, 10 reserved.
// - PLL reference bit 0 picks internal oscillator, 1 picks crystal.
`timescale 1ns/1ps
module clock_sel_div
   import clock_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire clock_ctrl_pkg::reg_req_t req,
   output logic [31:0] rdata_q,
   // Oscillator levels, sampled on clk
   input wire clock_ctrl_pkg::osc_in_t osc,
   input wire logic low_power_mode,
   // Analog status
   input wire logic pll_locked,
   input wire logic crystal_stable,
   // Generated clocks and state
   output clock_ctrl_pkg::clk_out_t clocks_q,
   output logic switch_busy_q,
   output logic [15:0] user_gate_q
);
   import clock_ctrl_pkg::*;

   typedef struct packed {
      logic [15:0] misc;
      logic [15:0] div;
      logic [15:0] gate;
      logic [15:0] stat;
      logic [31:0] rdata;
      logic xtal_prev;
      logic lock_prev;
      logic root_prev;
      logic [6:0] hcnt;
      logic [6:0] pcnt;
      logic [1:0] acnt;
      logic hclk;
      logic pclk;
      logic aclk;
      logic pll_ref;
   } top_st_t;

   top_st_t s_q;
   top_st_t s_d;
   logic root_q;
   logic busy;
   logic [1:0] sel_eff;
   logic [3:0] src_vec;
   logic root_rise;
   logic [2:0] hdiv;
   logic [2:0] pdiv;
   logic [6:0] hcnt_nx;
   logic [6:0] pcnt_nx;
   logic [1:0] acnt_nx;

   always_comb
   begin
      // Reserved code falls back to the fast oscillator
      if (low_power_mode)
      begin
         sel_eff = SRC_SLOW;
      end
      else if (s_q.misc[ROOT_SEL_LSB +: 2] == SEL_RSVD)
      begin
         sel_eff = SEL_FAST;
      end
      else
      begin
         sel_eff = s_q.misc[ROOT_SEL_LSB +: 2];
      end
   end

   // Source index order matches the select codes
   assign src_vec = {osc.external_clock_input, osc.slow_internal_osc,
                     osc.system_pll, osc.fast_internal_osc};

   glitch_free_mux u_mux (
      .clk(clk),
      .rstn(rstn),
      .src(src_vec),
      .sel(sel_eff),
      .out_q(root_q),
      .busy_q(busy)
   );

   assign root_rise = root_q && !s_q.root_prev;
   assign hdiv = s_q.div[HDIV_LSB +: 3];
   assign pdiv = s_q.div[PDIV_LSB +: 3];
   assign hcnt_nx = root_rise ? s_q.hcnt + 7'h01 : s_q.hcnt;
   assign pcnt_nx = root_rise ? s_q.pcnt + 7'h01 : s_q.pcnt;
   assign acnt_nx = root_rise ? s_q.acnt + 2'h1 : s_q.acnt;

   always_comb
   begin
      s_d = s_q;
      s_d.root_prev = root_q;
      s_d.hcnt = hcnt_nx;
      s_d.pcnt = pcnt_nx;
      s_d.acnt = acnt_nx;
      // Dividers by two to the power of the field
      if (hdiv == 3'h0)
      begin
         s_d.hclk = root_q;
      end
      else
      begin
         s_d.hclk = hcnt_nx[hdiv - 3'h1];
      end
      if (pdiv == 3'h0)
      begin
         s_d.pclk = root_q;
      end
      else
      begin
         s_d.pclk = pcnt_nx[pdiv - 3'h1];
      end
      s_d.aclk = acnt_nx[ACLK_LOG2 - 1];
      // PLL reference select
      if (s_q.misc[PLL_REF_BIT])
      begin
         s_d.pll_ref = osc.crystal_osc;
      end
      else
      begin
         s_d.pll_ref = osc.fast_internal_osc;
      end
      // Status levels and sticky events
      s_d.xtal_prev = crystal_stable;
      s_d.lock_prev = pll_locked;
      if (req.we && req.addr == STAT_OFS)
      begin
         s_d.stat = s_q.stat & ~(req.wdata[15:0] & STAT_W1C);
      end
      s_d.stat[XTAL_OK_BIT] = crystal_stable;
      s_d.stat[LOCK_BIT] = pll_locked;
      // A new event wins over a clear in the same cycle
      if (crystal_stable && !s_q.xtal_prev)
      begin
         s_d.stat[XTAL_GOT_BIT] = 1'b1;
      end
      if (!crystal_stable && s_q.xtal_prev)
      begin
         s_d.stat[XTAL_LOST_BIT] = 1'b1;
      end
      if (pll_locked && !s_q.lock_prev)
      begin
         s_d.stat[LOCK_GOT_BIT] = 1'b1;
      end
      if (!pll_locked && s_q.lock_prev)
      begin
         s_d.stat[LOCK_LOST_BIT] = 1'b1;
      end
      // Register writes
      if (req.we)
      begin
         case (req.addr)
            MISC_OFS: s_d.misc = req.wdata[15:0] & MISC_WMASK;
            DIV_OFS: s_d.div = req.wdata[15:0] & DIV_WMASK;
            GATE_OFS: s_d.gate = req.wdata[15:0];
            default: s_d.misc = s_q.misc;
         endcase
      end
      // Read data stands only in the cycle after the strobe
      s_d.rdata = 32'h0000_0000;
      if (req.re)
      begin
         case (req.addr)
            MISC_OFS: s_d.rdata = {16'h0000, s_q.misc};
            DIV_OFS: s_d.rdata = {16'h0000, s_q.div};
            GATE_OFS: s_d.rdata = {16'h0000, s_q.gate};
            STAT_OFS: s_d.rdata = {16'h0000, s_q.stat};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_q <= '0;
         s_q.misc <= MISC_RST;
         s_q.div <= DIV_RST;
         s_q.gate <= GATE_RST;
         s_q.stat <= STAT_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rdata_q = s_q.rdata;
   assign clocks_q = '{root_system_clock: root_q, hclk: s_q.hclk, pclk: s_q.pclk,
                       aclk: s_q.aclk, pll_ref: s_q.pll_ref};
   assign switch_busy_q = busy;
   assign user_gate_q = s_q.gate;

   sequence s_root_rise;
      root_q && !s_q.root_prev;
   endsequence

   sequence s_quiet_root;
      !root_rise [*2];
   endsequence

   property p_pll_ref;
      @(posedge clk) disable iff (!rstn)
      1'b1 |=> s_q.pll_ref == ($past(s_q.misc[PLL_REF_BIT]) ? $past(osc.crystal_osc)
                                                           : $past(osc.fast_internal_osc));
   endproperty
   a_pll_ref: assert property (p_pll_ref) else $error("wrong PLL reference");

   property p_sel_decode;
      @(posedge clk) disable iff (!rstn)
      !low_power_mode |-> sel_eff == ((s_q.misc[1:0] == SEL_RSVD) ? SEL_FAST : s_q.misc[1:0]);
   endproperty
   a_sel_decode: assert property (p_sel_decode) else $error("root select decode wrong");

   property p_low_power;
      @(posedge clk) disable iff (!rstn)
      low_power_mode |-> sel_eff == SRC_SLOW;
   endproperty
   a_low_power: assert property (p_low_power) else $error("slow oscillator not chosen");

   property p_aclk_steady;
      @(posedge clk) disable iff (!rstn)
      s_quiet_root |=> $stable(s_q.aclk);
   endproperty
   a_aclk_steady: assert property (p_aclk_steady) else $error("analog clock moved without root edge");

   property p_aclk_div;
      @(posedge clk) disable iff (!rstn)
      s_root_rise ##0 (s_q.acnt == 2'h3) |=> $fell(s_q.aclk) || !s_q.aclk;
   endproperty
   a_aclk_div: assert property (p_aclk_div) else $error("analog clock not root over four");

   property p_hclk_div1;
      @(posedge clk) disable iff (!rstn)
      hdiv == 3'h0 |=> s_q.hclk == $past(root_q);
   endproperty
   a_hclk_div1: assert property (p_hclk_div1) else $error("divide by one not passing root");

   property p_stat_read;
      @(posedge clk) disable iff (!rstn)
      req.re && req.addr == STAT_OFS |=> rdata_q == {16'h0000, $past(s_q.stat)} ##1 rdata_q == 32'h0000_0000 || $past(req.re);
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status read wrong");

   property p_lock_sticky;
      @(posedge clk) disable iff (!rstn)
      $rose(pll_locked) |=> s_q.stat[LOCK_GOT_BIT] && s_q.stat[LOCK_BIT];
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock event lost");

   property p_xtal_level;
      @(posedge clk) disable iff (!rstn)
      1'b1 |=> s_q.stat[XTAL_OK_BIT] == $past(crystal_stable);
   endproperty
   a_xtal_level: assert property (p_xtal_level) else $error("crystal status not tracking");
endmodule // clock_sel_div

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import clock_ctrl_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   reg_req_t req = '0;
   osc_in_t osc = '0;
   osc_in_t op = '0;
   logic low_power_mode = 1'b0;
   logic pll_locked = 1'b0;
   logic crystal_stable = 1'b0;
   logic [31:0] rdata_q;
   clk_out_t clocks_q;
   logic switch_busy_q;
   logic [15:0] user_gate_q;
   int mismatches = 0;
   int comparisons = 0;
   int seed = 32'hf400d124;
   int cyc = 0;
   int high_run = 0;
   logic watch = 1'b0;

   always #5 clk = ~clk;

   clock_sel_div DUT (.clk(clk), .rstn(rstn), .req(req), .rdata_q(rdata_q), .osc(osc),
      .low_power_mode(low_power_mode), .pll_locked(pll_locked), .crystal_stable(crystal_stable),
      .clocks_q(clocks_q), .switch_busy_q(switch_busy_q), .user_gate_q(user_gate_q));

   // All sources keep running, so every switch has both ends alive
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      op <= osc;
      osc.fast_internal_osc <= (cyc % 6) < 3;
      osc.system_pll <= (cyc % 4) < 2;
      osc.external_clock_input <= (cyc % 8) < 4;
      osc.crystal_osc <= (cyc % 10) < 5;
      osc.slow_internal_osc <= (cyc % 16) < 8;
   end

   // Every high pulse of the root clock lasts at least the shortest source half period
   always @(posedge clk)
   begin
      #1;
      if (clocks_q.root_system_clock === 1'b1)
         high_run = high_run + 1;
      else
      begin
         if (watch && high_run > 0)
            check("root pulse", 32'(high_run >= 2), 32'd1);
         high_run = 0;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= {16'h0000, d};
      req.we <= 1'b1;
      @(posedge clk);
      req.we <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk);
      req.addr <= a;
      req.re <= 1'b1;
      @(posedge clk);
      req.re <= 1'b0;
      #1;
      check("read data", rdata_q, exp);
   endtask

   // Waits for the switch to end, then compares root and reference with the sources
   task automatic follow(input logic [1:0] code, input logic lpm, input logic xref);
      logic e;
      int n;
      int q;
      n = 0;
      q = 0;
      repeat (3) @(posedge clk);
      // Idle must hold a few cycles, a queued select may restart the switch
      while (q < 3 && n < 200)
      begin
         @(posedge clk);
         #1;
         n++;
         q = (switch_busy_q === 1'b0) ? q + 1 : 0;
      end
      check("switch done", 32'(n < 200), 32'd1);
      repeat (2) @(posedge clk);
      repeat (24)
      begin
         @(posedge clk);
         #1;
         e = lpm ? op.slow_internal_osc : code == SEL_PLL ? op.system_pll :
            code == SEL_EXT ? op.external_clock_input : op.fast_internal_osc;
         check("root clock", 32'(clocks_q.root_system_clock), 32'(e));
         e = xref ? op.crystal_osc : op.fast_internal_osc;
         check("pll reference", 32'(clocks_q.pll_ref), 32'(e));
      end
   endtask

   function automatic logic near(input int a, input int b);
      return (a - b <= 1) && (b - a <= 1);
   endfunction

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clk);
      mismatches++;
      tally_and_finish;
   end

   initial
   begin
      logic [15:0] d;
      logic [2:0] h;
      logic [2:0] p;
      clk_out_t pc;
      int nr, nh, np, na;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      watch <= 1'b1;
      follow(SEL_PLL, 1'b0, 1'b0);
      rd(MISC_OFS, 32'h0000_0041);
      rd(DIV_OFS, 32'h0000_0200);
      rd(GATE_OFS, 32'h0000_0040);
      rd(STAT_OFS, 32'h0000_0000);
      rd(32'h4002_8008, 32'h0000_0000);
      $display("test reset done");
      repeat (6)
      begin
         d = 16'($random(seed));
         wr(GATE_OFS, d);
         wr(32'h4002_8010, ~d);
         rd(GATE_OFS, {16'h0000, d});
         check("gate copy", 32'(user_gate_q), 32'(d));
         wr(DIV_OFS, d);
         rd(DIV_OFS, {16'h0000, d & DIV_WMASK});
      end
      wr(MISC_OFS, 16'hFFFF);
      rd(MISC_OFS, 32'h0000_EFF3);
      $display("test registers done");
      for (int i = 0; i < 4; i++)
      begin
         d[1:0] = i == 0 ? SEL_FAST : i == 1 ? SEL_EXT : i == 2 ? SEL_RSVD : SEL_PLL;
         wr(MISC_OFS, 16'h0040 | {14'h0000, d[1:0]});
      end
      wr(MISC_OFS, 16'h0040);
      follow(SEL_FAST, 1'b0, 1'b0);
      wr(MISC_OFS, 16'h0043);
      follow(SEL_EXT, 1'b0, 1'b0);
      wr(MISC_OFS, 16'h0042);
      follow(SEL_FAST, 1'b0, 1'b0);
      low_power_mode <= 1'b1;
      follow(SEL_FAST, 1'b1, 1'b0);
      low_power_mode <= 1'b0;
      wr(MISC_OFS, 16'h0041);
      follow(SEL_PLL, 1'b0, 1'b0);
      $display("test root select done");
      crystal_stable <= 1'b1;
      repeat (3) @(posedge clk);
      rd(STAT_OFS, 32'h0000_5000);
      wr(MISC_OFS, 16'h0040);
      follow(SEL_FAST, 1'b0, 1'b0);
      repeat (5) @(posedge clk);
      wr(MISC_OFS, 16'h0840);
      pll_locked <= 1'b1;
      repeat (3) @(posedge clk);
      rd(STAT_OFS, 32'h0000_5003);
      wr(MISC_OFS, 16'h0841);
      follow(SEL_PLL, 1'b0, 1'b1);
      wr(STAT_OFS, 16'h6006);
      rd(STAT_OFS, 32'h0000_1001);
      pll_locked <= 1'b0;
      crystal_stable <= 1'b0;
      repeat (3) @(posedge clk);
      rd(STAT_OFS, 32'h0000_2004);
      wr(STAT_OFS, 16'h6006);
      rd(STAT_OFS, 32'h0000_0000);
      $display("test crystal sequence done");
      for (int k = 0; k < 8; k++)
      begin
         h = 3'(k);
         p = k == 0 ? 3'd2 : 3'($random(seed));
         wr(DIV_OFS, {5'h00, p, 5'h00, h});
         repeat (300) @(posedge clk);
         nr = 0;
         nh = 0;
         np = 0;
         na = 0;
         pc = clocks_q;
         repeat (2048)
         begin
            @(posedge clk);
            #1;
            nr += int'(clocks_q.root_system_clock && !pc.root_system_clock);
            nh += int'(clocks_q.hclk && !pc.hclk);
            np += int'(clocks_q.pclk && !pc.pclk);
            na += int'(clocks_q.aclk && !pc.aclk);
            pc = clocks_q;
         end
         check("hclk rate", 32'(near(nh, nr >> h)), 32'd1);
         check("pclk rate", 32'(near(np, nr >> p)), 32'd1);
         check("aclk rate", 32'(near(na, nr >> 2)), 32'd1);
      end
      $display("test dividers done");
      tally_and_finish;
   end
endmodule // tb_top
